// ### src/ppo_pkg.sv
// package: constants for the port pin override and sleep clamp block
package ppo_pkg;
    localparam int  PPO_PINS_DEF     = 8;
    localparam logic PPO_RST_BIT     = 1'b0;
    localparam logic [2:0] PPO_PULLUP_CODE = 3'h2;
    localparam int  PPO_CLK_PERIOD_NS = 100;
    localparam int  PPO_SYNC_STAGES  = 2;
    typedef enum logic [1:0] {
        PPO_MODE_ACTIVE   = 2'h0,
        PPO_MODE_IDLE     = 2'h1,
        PPO_MODE_DEEP     = 2'h2,
        PPO_MODE_RSVD     = 2'h3
    } ppo_mode_t;
endpackage : ppo_pkg

// ### src/ppo_pin.sv
// module: logic of one port pin
`timescale 1ns/10ps
`default_nettype none
module ppo_pin (
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    input  wire logic sleep_clamp_i,
    input  wire logic global_pullup_kill_i,
    input  wire logic pin_drive_select_bit_i,
    input  wire logic pin_output_value_bit_i,
    input  wire logic pullup_override_enable_i,
    input  wire logic pullup_override_value_i,
    input  wire logic drive_override_enable_i,
    input  wire logic drive_override_value_i,
    input  wire logic value_override_enable_i,
    input  wire logic value_override_value_i,
    input  wire logic input_gate_override_enable_i,
    input  wire logic input_gate_override_value_i,
    input  wire logic pad_i,
    output logic      pad_o,
    output logic      pad_oe_o,
    output logic      pullup_o,
    output logic      raw_pin_input_to_alt_o,
    output logic      pin_sample_bit_o
);
    import ppo_pkg::*;

    typedef struct packed {
        logic oe;
        logic val;
        logic pu;
        logic raw_meta;
        logic raw;
        logic smp;
    } ppo_pin_st_t;

    ppo_pin_st_t st_q;
    ppo_pin_st_t st_d;
    logic        in_en;
    logic        gated;

    always_comb begin
        st_d = st_q;
        // drive enable and value
        st_d.oe  = drive_override_enable_i ? drive_override_value_i
                                           : pin_drive_select_bit_i; // R8 R9 R18
        st_d.val = value_override_enable_i ? value_override_value_i
                                           : pin_output_value_bit_i; // R10 R11
        // pull-up
        if (pullup_override_enable_i) begin
            st_d.pu = pullup_override_value_i; // R7
        end else begin
            st_d.pu = ({pin_drive_select_bit_i, pin_output_value_bit_i,
                        global_pullup_kill_i} == PPO_PULLUP_CODE); // R6 R19
        end
        // input gate and clamp to ground
        in_en = input_gate_override_enable_i ? input_gate_override_value_i
                                             : ~sleep_clamp_i; // R12 R13 R1
        gated = pad_i & in_en; // R1
        st_d.raw_meta = gated;
        st_d.raw      = st_q.raw_meta; // R14
        st_d.smp      = st_q.raw; // R21
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q <= '0; // R5 R20
        end else begin
            st_q <= st_d;
        end
    end

    assign pad_oe_o               = st_q.oe;
    assign pad_o                  = st_q.val;
    assign pullup_o               = st_q.pu;
    assign raw_pin_input_to_alt_o = st_q.raw;
    assign pin_sample_bit_o       = st_q.smp;

    property p_pull_rule;
        @(posedge clk_i) disable iff (!rst_b_i)
        (!pullup_override_enable_i && global_pullup_kill_i) |=> !pullup_o;
    endproperty
    a_pull_rule: assert property (p_pull_rule) // R19
        else $error("pull-up on while globally disabled");

    property p_pull_ovr;
        @(posedge clk_i) disable iff (!rst_b_i)
        pullup_override_enable_i |=> (pullup_o == $past(pullup_override_value_i));
    endproperty
    a_pull_ovr: assert property (p_pull_ovr) // R7
        else $error("pull-up ignores override");

    property p_drive_ovr;
        @(posedge clk_i) disable iff (!rst_b_i)
        drive_override_enable_i |=> (pad_oe_o == $past(drive_override_value_i));
    endproperty
    a_drive_ovr: assert property (p_drive_ovr) // R9
        else $error("driver ignores override");

    property p_drive_reg;
        @(posedge clk_i) disable iff (!rst_b_i)
        !drive_override_enable_i |=> (pad_oe_o == $past(pin_drive_select_bit_i));
    endproperty
    a_drive_reg: assert property (p_drive_reg) // R8
        else $error("driver not from direction bit");

    property p_val_ovr;
        @(posedge clk_i) disable iff (!rst_b_i)
        value_override_enable_i |=> (pad_o == $past(value_override_value_i));
    endproperty
    a_val_ovr: assert property (p_val_ovr) // R11
        else $error("value ignores override");

    property p_clamp;
        @(posedge clk_i) disable iff (!rst_b_i)
        (sleep_clamp_i && !input_gate_override_enable_i)[*2] |=> !raw_pin_input_to_alt_o;
    endproperty
    a_clamp: assert property (p_clamp) // R1
        else $error("input not clamped in sleep");

    property p_gate_ovr;
        @(posedge clk_i) disable iff (!rst_b_i)
        (input_gate_override_enable_i && !input_gate_override_value_i)[*2]
            |=> !raw_pin_input_to_alt_o;
    endproperty
    a_gate_ovr: assert property (p_gate_ovr) // R13
        else $error("input gate override ignored");

    property p_sample;
        @(posedge clk_i) disable iff (!rst_b_i)
        ##1 1'b1 |-> (pin_sample_bit_o == $past(raw_pin_input_to_alt_o));
    endproperty
    a_sample: assert property (p_sample) // R21
        else $error("sample bit not one stage behind");
endmodule : ppo_pin
`default_nettype wire

// ### src/ppo_port.sv
// module: one port of pins with sleep clamp and alternate-function overrides
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// R1: sleep clamp grounds input before trigger
// R2: clamp in deep sleep, never active/idle
// R3: enabled external interrupt bypasses clamp
// R4: clamp release sets flag on high pin
// R5: pull-ups off during reset
// R6: no override: pull-up when code 010
// R7: pull-up override value wins outright
// R8: driver enable from override or direction
// R9: drive override value wins outright
// R10: driven value from override or bit
// R11: value override ignores output bit
// R12: input enable from override or sleep
// R13: input gate override ignores sleep state
// R14: alternate modules get raw input after two register stages
// R15: analog path wired straight to pad
// R16: peripherals supply override signals
// R17: strobes per port, clamp global, overrides per pin
// R18: direction one drives, zero inputs
// R19: global kill turns off all pull-ups without override
// R20: pins tri-state immediately on reset
// R21: sample bit through two-stage synchroniser
module ppo_port #(
    parameter int PINS = ppo_pkg::PPO_PINS_DEF
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_b_i,
    input  wire ppo_pkg::ppo_mode_t   sleep_mode_i,
    input  wire logic                 global_pullup_kill_i,
    input  wire logic [PINS-1:0]      pin_drive_select_bit_i,
    input  wire logic [PINS-1:0]      pin_output_value_bit_i,
    input  wire logic [PINS-1:0]      ext_irq_pin_i,
    input  wire logic [PINS-1:0]      ext_irq_enable_i,
    input  wire logic [PINS-1:0]      ext_irq_async_edge_i,
    input  wire logic [PINS-1:0]      ext_irq_flag_clear_i,
    input  wire logic [PINS-1:0]      pullup_override_enable_i,
    input  wire logic [PINS-1:0]      pullup_override_value_i,
    input  wire logic [PINS-1:0]      drive_override_enable_i,
    input  wire logic [PINS-1:0]      drive_override_value_i,
    input  wire logic [PINS-1:0]      value_override_enable_i,
    input  wire logic [PINS-1:0]      value_override_value_i,
    input  wire logic [PINS-1:0]      input_gate_override_enable_i,
    input  wire logic [PINS-1:0]      input_gate_override_value_i,
    // analog path taps the pad ahead of this logic and is never gated here
    input  wire logic [PINS-1:0]      pad_i, // R15
    output logic      [PINS-1:0]      pad_o,
    output logic      [PINS-1:0]      pad_oe_o,
    output logic      [PINS-1:0]      pullup_o,
    output logic      [PINS-1:0]      raw_pin_input_to_alt_o,
    output logic      [PINS-1:0]      pin_sample_bit_o,
    output logic      [PINS-1:0]      ext_irq_flag_o,
    output logic                      sleep_clamp_o
);
    import ppo_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic            clamp;
        logic [PINS-1:0] prev_raw;
        logic [PINS-1:0] flag;
    } ppo_port_st_t;

    ppo_port_st_t st_q;
    ppo_port_st_t st_d;

    logic [PINS-1:0] gate_en;
    logic [PINS-1:0] gate_val;
    logic [PINS-1:0] raw_w;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        st_d = st_q;
        unique case (sleep_mode_i)
            PPO_MODE_ACTIVE: st_d.clamp = 1'b0; // R2
            PPO_MODE_IDLE:   st_d.clamp = 1'b0; // R2
            PPO_MODE_DEEP:   st_d.clamp = 1'b1; // R2
            default:         st_d.clamp = 1'b0;
        endcase
        st_d.prev_raw = raw_w;
        for (int i = 0; i < PINS; i++) begin
            // edge after clamp release is a real change and sets the flag
            if (ext_irq_pin_i[i] && ext_irq_async_edge_i[i]
                && (raw_w[i] != st_q.prev_raw[i])) begin
                st_d.flag[i] = 1'b1; // R4
            end else if (ext_irq_flag_clear_i[i]) begin
                st_d.flag[i] = 1'b0;
            end
        end
    end

    // enabled external interrupt holds the input gate open
    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            if (ext_irq_pin_i[i] && ext_irq_enable_i[i]) begin
                gate_en[i]  = 1'b1; // R3
                gate_val[i] = 1'b1; // R3
            end else begin
                gate_en[i]  = input_gate_override_enable_i[i];
                gate_val[i] = input_gate_override_value_i[i];
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************
    // pins
    // ****************************************
    for (genvar g = 0; g < PINS; g++) begin : g_pin
        ppo_pin u_pin (
            .clk_i                        (clk_i),
            .rst_b_i                      (rst_b_i),
            .sleep_clamp_i                (st_q.clamp), // R17
            .global_pullup_kill_i         (global_pullup_kill_i),
            .pin_drive_select_bit_i       (pin_drive_select_bit_i[g]),
            .pin_output_value_bit_i       (pin_output_value_bit_i[g]),
            .pullup_override_enable_i     (pullup_override_enable_i[g]),
            .pullup_override_value_i      (pullup_override_value_i[g]),
            .drive_override_enable_i      (drive_override_enable_i[g]),
            .drive_override_value_i       (drive_override_value_i[g]),
            .value_override_enable_i      (value_override_enable_i[g]),
            .value_override_value_i       (value_override_value_i[g]),
            .input_gate_override_enable_i (gate_en[g]),
            .input_gate_override_value_i  (gate_val[g]),
            .pad_i                        (pad_i[g]),
            .pad_o                        (pad_o[g]),
            .pad_oe_o                     (pad_oe_o[g]),
            .pullup_o                     (pullup_o[g]),
            .raw_pin_input_to_alt_o       (raw_w[g]), // R14
            .pin_sample_bit_o             (pin_sample_bit_o[g])
        );
    end

    assign raw_pin_input_to_alt_o = raw_w;
    assign ext_irq_flag_o         = st_q.flag;
    assign sleep_clamp_o          = st_q.clamp;

    // ****************************************
    // checks
    // ****************************************
    property p_clamp_modes;
        @(posedge clk_i) disable iff (!rst_b_i)
        (sleep_mode_i == PPO_MODE_DEEP) |=> sleep_clamp_o;
    endproperty
    a_clamp_modes: assert property (p_clamp_modes) // R2
        else $error("clamp missing in deep sleep");

    property p_no_clamp_active;
        @(posedge clk_i) disable iff (!rst_b_i)
        (sleep_mode_i inside {PPO_MODE_ACTIVE, PPO_MODE_IDLE}) |=> !sleep_clamp_o;
    endproperty
    a_no_clamp_active: assert property (p_no_clamp_active) // R2
        else $error("clamp in active or idle");

    property p_flag_set_wins;
        @(posedge clk_i) disable iff (!rst_b_i)
        (ext_irq_pin_i[0] && ext_irq_async_edge_i[0]
         && raw_w[0] != st_q.prev_raw[0]) |=> ext_irq_flag_o[0];
    endproperty
    a_flag_set_wins: assert property (p_flag_set_wins) // R4
        else $error("interrupt flag not set on change");

    property p_irq_bypass;
        @(posedge clk_i) disable iff (!rst_b_i)
        (ext_irq_pin_i[0] && ext_irq_enable_i[0] && pad_i[0])[*3]
            |-> raw_w[0];
    endproperty
    a_irq_bypass: assert property (p_irq_bypass) // R3
        else $error("enabled interrupt pin clamped");

    property p_clamp_rsvd;
        @(posedge clk_i) disable iff (!rst_b_i)
        (sleep_mode_i == PPO_MODE_RSVD) |=> !sleep_clamp_o;
    endproperty
    a_clamp_rsvd: assert property (p_clamp_rsvd) // R2
        else $error("clamp in unused mode code");

    // async reset clears the pins before any clock edge arrives
    property p_reset_quiet;
        @(posedge clk_i)
        (!rst_b_i)[*2]
            |-> ((pullup_o == '0) && (pad_oe_o == '0));
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) // R5 R20
        else $error("pin driven or pulled up in reset");

    // ****************************************
    // per-pin checks
    // ****************************************
    // raw input follows an open gate two edges later
    for (genvar g = 0; g < PINS; g++) begin : g_chk
        property p_pull_code;
            @(posedge clk_i) disable iff (!rst_b_i)
            !pullup_override_enable_i[g] |=> (pullup_o[g] == $past(!pin_drive_select_bit_i[g]
                && pin_output_value_bit_i[g] && !global_pullup_kill_i));
        endproperty
        a_pull_code: assert property (p_pull_code) // R6
            else $error("pull-up not set by direction and value bits");

        // without overrides the register bits steer the pin
        property p_val_reg;
            @(posedge clk_i) disable iff (!rst_b_i)
            !value_override_enable_i[g] |=> (pad_o[g] == $past(pin_output_value_bit_i[g]));
        endproperty
        a_val_reg: assert property (p_val_reg) // R10
            else $error("driven value not from output bit");

        property p_dir_out;
            @(posedge clk_i) disable iff (!rst_b_i)
            (!drive_override_enable_i[g] && pin_drive_select_bit_i[g]) |=> pad_oe_o[g];
        endproperty
        a_dir_out: assert property (p_dir_out) // R18
            else $error("direction one does not drive");

        property p_dir_in;
            @(posedge clk_i) disable iff (!rst_b_i)
            (!drive_override_enable_i[g] && !pin_drive_select_bit_i[g]) |=> !pad_oe_o[g];
        endproperty
        a_dir_in: assert property (p_dir_in) // R18
            else $error("direction zero still drives");

        property p_open_awake;
            @(posedge clk_i) disable iff (!rst_b_i)
            (!input_gate_override_enable_i[g] && !ext_irq_enable_i[g] && !sleep_clamp_o
             && pad_i[g])[*2] |=> raw_pin_input_to_alt_o[g];
        endproperty
        a_open_awake: assert property (p_open_awake) // R12
            else $error("awake input gated off");

        property p_gate_open;
            @(posedge clk_i) disable iff (!rst_b_i)
            (input_gate_override_enable_i[g] && input_gate_override_value_i[g] && pad_i[g])[*2]
                |=> raw_pin_input_to_alt_o[g];
        endproperty
        a_gate_open: assert property (p_gate_open) // R13
            else $error("open input gate override ignored");

        property p_irq_open;
            @(posedge clk_i) disable iff (!rst_b_i)
            (ext_irq_pin_i[g] && ext_irq_enable_i[g] && pad_i[g])[*2]
                |=> raw_pin_input_to_alt_o[g];
        endproperty
        a_irq_open: assert property (p_irq_open) // R3
            else $error("enabled interrupt pin gated off");

        property p_irq_clamped;
            @(posedge clk_i) disable iff (!rst_b_i)
            (ext_irq_pin_i[g] && !ext_irq_enable_i[g] && !input_gate_override_enable_i[g]
             && sleep_clamp_o)[*2] |=> !raw_pin_input_to_alt_o[g];
        endproperty
        a_irq_clamped: assert property (p_irq_clamped) // R3
            else $error("disabled interrupt pin not clamped");

        // flag: any raw change on an edge-armed pin sets it, set beats clear
        property p_flag_set;
            @(posedge clk_i) disable iff (!rst_b_i)
            (ext_irq_pin_i[g] && ext_irq_async_edge_i[g]
             && $changed(raw_pin_input_to_alt_o[g])) |=> ext_irq_flag_o[g];
        endproperty
        a_flag_set: assert property (p_flag_set) // R4
            else $error("interrupt flag missed a change");

        property p_flag_hold;
            @(posedge clk_i) disable iff (!rst_b_i)
            (ext_irq_flag_o[g] && !ext_irq_flag_clear_i[g]) |=> ext_irq_flag_o[g];
        endproperty
        a_flag_hold: assert property (p_flag_hold) // R4
            else $error("interrupt flag dropped without clear");

        property p_flag_clear;
            @(posedge clk_i) disable iff (!rst_b_i)
            (ext_irq_flag_clear_i[g] && !(ext_irq_pin_i[g] && ext_irq_async_edge_i[g]
             && $changed(raw_pin_input_to_alt_o[g]))) |=> !ext_irq_flag_o[g];
        endproperty
        a_flag_clear: assert property (p_flag_clear) // R4
            else $error("interrupt flag survived clear");

        property p_flag_quiet;
            @(posedge clk_i) disable iff (!rst_b_i)
            (!ext_irq_flag_o[g] && !(ext_irq_pin_i[g] && ext_irq_async_edge_i[g]
             && $changed(raw_pin_input_to_alt_o[g]))) |=> !ext_irq_flag_o[g];
        endproperty
        a_flag_quiet: assert property (p_flag_quiet) // R4
            else $error("interrupt flag set without change");
    end
endmodule : ppo_port
`default_nettype wire

// ### testbench/ppo_alt_model.sv
// file: model of the peripherals that own alternate pin functions
`timescale 1ns/10ps
`default_nettype none
module ppo_alt_model #(
    parameter int P = 8
) (
    input  wire logic                clk_i,
    input  wire logic                rst_b_i,
    input  wire logic [3:0]          own_i,
    input  wire logic [P-1:0]        val_i,
    output logic      [3:0][P-1:0]   en_o,
    output logic      [3:0][P-1:0]   val_o
);
    // slot 0 pull-up, 1 drive, 2 value, 3 input gate; made inside the peripheral
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            en_o  <= '0;
            val_o <= '0;
        end else begin
            for (int k = 0; k < 4; k++) begin
                en_o[k]  <= {P{own_i[k]}};
                val_o[k] <= val_i;
            end
        end
    end
endmodule : ppo_alt_model
`default_nettype wire

// ### testbench/tb_top.sv
// file: self-checking bench of the port pin override block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import ppo_pkg::*;
    logic clk = 1'b0, rst_b_i = 1'b0, kill = 1'b0, clamp;
    ppo_mode_t mode = PPO_MODE_ACTIVE;
    logic [7:0] dir = '0, outv = 8'hFF, xp = '0, xe = '0, xa = '0, xc = '0, pad = '0;
    logic [7:0] pad_o, oe, pu, raw, smp, flag, val = '0;
    logic [3:0] own = '0;
    logic [3:0][7:0] oen, oval;
    int err_total = 0, check_count = 0;
    ppo_mode_t ml[4] = '{PPO_MODE_ACTIVE, PPO_MODE_IDLE, PPO_MODE_RSVD, PPO_MODE_DEEP};

    always #(PPO_CLK_PERIOD_NS / 2) clk = ~clk;

    ppo_alt_model #(.P(8)) ALT (.clk_i(clk), .rst_b_i(rst_b_i), .own_i(own), .val_i(val),
        .en_o(oen), .val_o(oval));

    ppo_port #(.PINS(8)) DUT (.clk_i(clk), .rst_b_i(rst_b_i), .sleep_mode_i(mode),
        .global_pullup_kill_i(kill), .pin_drive_select_bit_i(dir),
        .pin_output_value_bit_i(outv), .ext_irq_pin_i(xp), .ext_irq_enable_i(xe),
        .ext_irq_async_edge_i(xa), .ext_irq_flag_clear_i(xc),
        .pullup_override_enable_i(oen[0]), .pullup_override_value_i(oval[0]),
        .drive_override_enable_i(oen[1]), .drive_override_value_i(oval[1]),
        .value_override_enable_i(oen[2]), .value_override_value_i(oval[2]),
        .input_gate_override_enable_i(oen[3]), .input_gate_override_value_i(oval[3]),
        .pad_i(pad), .pad_o(pad_o), .pad_oe_o(oe), .pullup_o(pu),
        .raw_pin_input_to_alt_o(raw), .pin_sample_bit_o(smp), .ext_irq_flag_o(flag),
        .sleep_clamp_o(clamp));

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // model register plus design register, then margin
    task automatic settle();
        repeat (4) @(negedge clk);
    endtask : settle

    task automatic done(input string nm);
        $display("test %s finished", nm);
    endtask : done

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    // ****************************************
    // tests
    // ****************************************
    initial begin
        repeat (10) @(negedge clk);
        check("pullup", pu, 8'h00);
        check("oe", oe, 8'h00);
        repeat (10) @(negedge clk);
        rst_b_i = 1'b1;
        settle();
        check("pullup", pu, 8'hFF);
        kill = 1'b1;
        settle();
        check("pullup", pu, 8'h00);
        kill = 1'b0;
        dir = 8'h0F;
        outv = 8'h33;
        settle();
        check("pullup", pu, 8'h30);
        check("oe", oe, 8'h0F);
        check("pad", pad_o & 8'h0F, 8'h03);
        done("plain");
        own = 4'h1;
        val = 8'h0F;
        settle();
        check("pullup", pu, 8'h0F);
        own = 4'h2;
        val = 8'hF0;
        settle();
        check("oe", oe, 8'hF0);
        own = 4'h4;
        val = 8'h55;
        settle();
        check("pad", pad_o & 8'h0F, 8'h05);
        done("override");
        own = 4'h0;
        dir = 8'h00;
        outv = 8'h00;
        pad = 8'hFF;
        foreach (ml[i]) begin
            mode = ml[i];
            settle();
            check("clamp", {7'h00, clamp}, {7'h00, mode == PPO_MODE_DEEP});
            check("raw", raw, (mode == PPO_MODE_DEEP) ? 8'h00 : 8'hFF);
        end
        own = 4'h8;
        val = 8'hC3;
        settle();
        check("raw", raw, 8'hC3);
        mode = PPO_MODE_ACTIVE;
        val = 8'h00;
        settle();
        check("raw", raw, 8'h00);
        own = 4'h0;
        pad = 8'h00;
        settle();
        pad = 8'hFF;
        @(negedge clk);
        check("raw", raw, 8'h00);
        @(negedge clk);
        check("raw", raw, 8'hFF);
        check("sample", smp, 8'h00);
        @(negedge clk);
        check("sample", smp, 8'hFF);
        done("input");
        xp = 8'hFF;
        xe = 8'h0F;
        mode = PPO_MODE_DEEP;
        settle();
        check("raw", raw, 8'h0F);
        xe = 8'h00;
        xa = 8'hFF;
        settle();
        check("raw", raw, 8'h00);
        xc = 8'hFF;
        @(negedge clk);
        xc = 8'h00;
        settle();
        check("flag", flag, 8'h00);
        mode = PPO_MODE_ACTIVE;
        settle();
        check("flag", flag, 8'hFF);
        xc = 8'hFF;
        @(negedge clk);
        xc = 8'h00;
        settle();
        check("flag", flag, 8'h00);
        done("wake");
        dir = 8'hFF;
        outv = 8'h00;
        settle();
        check("oe", oe, 8'hFF);
        rst_b_i = 1'b0;
        #1;
        check("oe", oe, 8'h00);
        repeat (20) @(negedge clk);
        rst_b_i = 1'b1;
        done("reset");
        finish_test();
    end

    initial begin
        #(PPO_CLK_PERIOD_NS * 2000);
        err_total++;
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
